// *** rtl/lwp_pkg.sv ***
// Shared constants for the write-path timing and masked-write block.
package lwp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CCD_BL16 = 8;
  localparam int unsigned CCDMW = 4 * CCD_BL16;
  localparam int unsigned PREAMBLE_CK = 2;
  localparam int unsigned WR_TIME_NS = 400;
  localparam int unsigned WR_CYC = (WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WTR_TIME_NS = 200;
  localparam int unsigned WTR_CYC = (WTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BEATS_BL16 = 16;
  localparam int unsigned BEATS_BL32 = 32;
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_WR = 3'h1;
  localparam logic [2:0] CMD_MWR1 = 3'h2;
  localparam logic [2:0] CMD_CAS2 = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h5;
  typedef enum logic [1:0] {LWP_IDLE, LWP_WAITCAS, LWP_BURST} lwp_state_t;
endpackage : lwp_pkg

// *** rtl/lwp_write_path.sv ***
// Device-side write burst capture, masking and recovery timing for one channel.
`timescale 1ns/1ps
//
// Contract
// - Write recovery counts after last strobe edge.
// - Write-to-read counts after last strobe edge.
// - Seamless writes merge postamble and preamble.
// - Gapped writes keep postamble and preamble.
// - One mask signal per lane, data timing.
// - Postamble half cycle, optionally one more.
module lwp_write_path
  import lwp_pkg::*;
#(
  parameter int unsigned LANES = 2,
  parameter int unsigned CNTW = 8
)(
  input wire logic core_clk, // System clock, 20 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [2:0] cmd, // Decoded command, core domain.
  input wire logic bl32, // Burst length 32 selected by mode register.
  input wire logic [7:0] wl, // Write latency in clocks.
  input wire logic strobe, // Write strobe pin, asynchronous.
  input wire logic [8*LANES-1:0] dq, // Write data pins, asynchronous.
  input wire logic [LANES-1:0] dmi, // Mask pins, one per lane, asynchronous.
  output logic [8*LANES-1:0] wrData, // Merged column word of the last beat.
  output logic wrValid, // Pulse when a beat is committed.
  output logic burstDone, // Pulse on the edge after the last beat.
  output logic recoveryBusy, // High while write recovery runs.
  output logic turnBusy, // High while write-to-read turnaround runs.
  output logic mwrBusy // High while masked-write spacing runs.
);

  // All module state lives in one packed struct.
  typedef struct packed {
    lwp_state_t st;
    logic [1:0] strbS; // Strobe synchroniser, bit 0 first stage.
    logic strbLast; // Previous synchronised strobe, for edge finding.
    logic [8*LANES-1:0] dqS1;
    logic [8*LANES-1:0] dqS2;
    logic [LANES-1:0] dmS1;
    logic [LANES-1:0] dmS2;
    logic masked; // Current burst is a masked write.
    logic [5:0] beats; // Beats left in the burst.
    logic [CNTW-1:0] wrCnt;
    logic [CNTW-1:0] wtrCnt;
    logic [CNTW-1:0] mwCnt;
    logic [8*LANES-1:0] col; // Stored column word.
    logic valid;
    logic done;
    // Busy flags are kept as registers so that every output leaves a flip-flop.
    // Each flag is computed from the next counter value.
    // That keeps it in the same cycle as the counter it mirrors.
    logic recBusy; // Write recovery interval running.
    logic wtrBusy; // Write-to-read turnaround running.
    logic mwBusy; // Masked-write spacing running.
  } lwp_regs_t;

  lwp_regs_t r;
  lwp_regs_t next_r;
  logic rise;

  // Rising strobe edge, seen only on the second synchroniser stage.
  assign rise = r.strbS[1] & ~r.strbLast;

  // Next-state logic.
  always_comb
  begin
    next_r = r;
    next_r.strbS = {r.strbS[0], strobe};
    next_r.strbLast = r.strbS[1];
    next_r.dqS1 = dq;
    next_r.dqS2 = r.dqS1;
    next_r.dmS1 = dmi;
    next_r.dmS2 = r.dmS1;
    next_r.valid = 1'b0;
    next_r.done = 1'b0;
    // Counters run down; each reload restarts its interval.
    if (r.wrCnt != '0) next_r.wrCnt = r.wrCnt - 1'b1;
    if (r.wtrCnt != '0) next_r.wtrCnt = r.wtrCnt - 1'b1;
    if (r.mwCnt != '0) next_r.mwCnt = r.mwCnt - 1'b1;
    unique case (r.st)
      LWP_IDLE:
      begin
        if (cmd == CMD_WR || cmd == CMD_MWR1)
        begin
          // The column address cycle follows the first cycle at once.
          next_r.masked = (cmd == CMD_MWR1);
          next_r.st = LWP_WAITCAS;
        end
      end
      LWP_WAITCAS:
      begin
        if (cmd == CMD_CAS2)
        begin
          // Masked writes move sixteen beats even at BL32.
          next_r.beats = (bl32 && !r.masked) ? 6'(BEATS_BL32) : 6'(BEATS_BL16);
          if (r.masked) next_r.mwCnt = CNTW'(CCDMW);
          next_r.st = LWP_BURST;
        end
        else
        begin
          next_r.st = LWP_IDLE;
        end
      end
      LWP_BURST:
      begin
        // Every strobe rise seen in a burst counts as a beat, preamble edges included.
        // Back-to-back bursts simply keep edges flowing; a new command rearms.
        // Postamble edges after the last beat arrive in idle and are ignored.
        // This holds for the short postamble and for the extended one alike.
        if (rise)
        begin
          // Data and mask of one lane share sampling.
          for (int i = 0; i < int'(LANES); i++)
          begin
            if (!(r.masked && r.dmS2[i])) next_r.col[8*i +: 8] = r.dqS2[8*i +: 8];
          end
          next_r.valid = 1'b1;
          next_r.beats = r.beats - 6'h01;
          if (r.beats == 6'h01)
          begin
            // Intervals start on the edge after the last latching edge.
            next_r.done = 1'b1;
            next_r.wrCnt = CNTW'(WR_CYC);
            next_r.wtrCnt = CNTW'(WTR_CYC);
            next_r.st = LWP_IDLE;
          end
        end
      end
      default: next_r.st = LWP_IDLE;
    endcase
    // Flags follow the counters after every reload and every decrement.
    next_r.recBusy = (next_r.wrCnt != '0);
    next_r.wtrBusy = (next_r.wtrCnt != '0);
    next_r.mwBusy = (next_r.mwCnt != '0);
  end

  // State register, synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wrData = r.col;
  assign wrValid = r.valid;
  assign burstDone = r.done;
  // The write latency input is not used here.
  // The controller places the first latching edge, and the block only counts edges.
  assign recoveryBusy = r.recBusy;
  assign turnBusy = r.wtrBusy;
  assign mwrBusy = r.mwBusy;

  // Recovery starts at the end of the burst with the full count.
  AST_WR_START: assert property (@(posedge core_clk) disable iff (!resetn)
    burstDone |-> r.wrCnt == CNTW'(WR_CYC) && r.wtrCnt == CNTW'(WTR_CYC))
    else $error("recovery counters not loaded at burst end");
  AST_WTR_RUN: assert property (@(posedge core_clk) disable iff (!resetn)
    burstDone |=> turnBusy)
    else $error("turnaround not running after burst");
  AST_MW_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.st == LWP_WAITCAS && r.masked && cmd == CMD_CAS2) |=> r.mwCnt == CNTW'(CCDMW))
    else $error("masked spacing not loaded");
  AST_MW16: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.st == LWP_WAITCAS && r.masked && cmd == CMD_CAS2) |=> r.beats == 6'(BEATS_BL16))
    else $error("masked write not sixteen beats");
  AST_CAS: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.st == LWP_WAITCAS && cmd != CMD_CAS2) |=> r.st == LWP_IDLE)
    else $error("missing second cycle not dropped");
  AST_MASK: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.st == LWP_BURST && rise && r.masked && r.dmS2[0]) |=> wrData[7:0] == $past(r.col[7:0]))
    else $error("masked byte was changed");

  // Last latching edge of a burst: a strobe rise with one beat left.
  sequence sLastEdge;
    r.st == LWP_BURST && rise && r.beats == 6'h01;
  endsequence

  // Second cycle of a masked write, which arms the spacing interval.
  sequence sMaskedStart;
    r.st == LWP_WAITCAS && r.masked && cmd == CMD_CAS2;
  endsequence

  // Both intervals start on the edge after the last latching edge.
  AST_LAST_EDGE: assert property (@(posedge core_clk) disable iff (!resetn)
    sLastEdge |=> burstDone && recoveryBusy && turnBusy)
    else $error("intervals not started after last beat");

  // The spacing flag stays up for at least the first eight cycles.
  AST_MW_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    sMaskedStart |=> mwrBusy [*8])
    else $error("masked spacing dropped early");

  // A committed beat only comes from a running burst.
  AST_VALID_SRC: assert property (@(posedge core_clk) disable iff (!resetn)
    wrValid |-> $past(r.st) == LWP_BURST)
    else $error("beat committed outside a burst");

  // The end pulse comes with the last beat and leaves the block idle.
  AST_DONE_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
    burstDone |-> wrValid && r.st == LWP_IDLE)
    else $error("burst end without last beat");

  // Recovery is the longer interval, so it covers the turnaround.
  AST_REC_COVER: assert property (@(posedge core_clk) disable iff (!resetn)
    turnBusy |-> recoveryBusy)
    else $error("turnaround outlived recovery");

  // The registered flag mirrors its counter.
  AST_REC_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
    recoveryBusy == (r.wrCnt != '0))
    else $error("recovery flag out of step");
endmodule : lwp_write_path

// *** test/lwp_ctl_model.sv ***
// Controller model that issues write commands and drives strobe, data and mask pins.
`timescale 1ns/1ps
module lwp_ctl_model
  import lwp_pkg::*;
(
  output logic [2:0] cmd, // Command to the device.
  output logic strobe, // Write strobe, still outside frames.
  output logic [15:0] dq, // Write data for both lanes.
  output logic [1:0] dmi // One mask line per lane.
);
  // Pins start low, and nothing moves before the first command.
  initial
  begin
    cmd = CMD_NOP;
    strobe = 1'b0;
    dq = 16'h0000;
    dmi = 2'h0;
  end

  // Sends one command, with its second cycle only if pair is set, then a burst with strobe period of 400 ns.
  // Callers enter just after a clock edge, so every change stays off the sampling edge.
  task automatic burst(input logic [2:0] c, input logic pair, input int beats, input logic [15:0] d,
                       input logic [1:0] m);
    cmd = c;
    #50 cmd = pair ? CMD_CAS2 : CMD_NOP;
    #50 cmd = CMD_NOP;
    #(50 * PREAMBLE_CK);
    for (int i = 0; i < beats; i++)
    begin
      dq = d;
      dmi = m;
      #200 strobe = 1'b1;
      #200 strobe = 1'b0;
    end
    // Released pins show the inverse so that a stale value cannot pass.
    dq = ~d;
    dmi = ~m;
  endtask : burst
endmodule : lwp_ctl_model

// *** test/lwp_write_path_tb_top.sv ***
// Top-level bench for the write path block.
`timescale 1ns/1ps
module lwp_write_path_tb_top;
  import lwp_pkg::*;
  logic core_clk, resetn, bl32, strobe, wrValid, burstDone, recoveryBusy, turnBusy, mwrBusy;
  logic [2:0] cmd; // Command lines.
  logic [15:0] dq, wrData; // Data in and stored word.
  logic [1:0] dmi; // Mask lines.
  int fail_count, cmp_count, nBeats; // Verdict counters and committed beats.

  lwp_write_path uut (.core_clk(core_clk), .resetn(resetn), .cmd(cmd), .bl32(bl32), .wl(8'h08),
    .strobe(strobe), .dq(dq), .dmi(dmi), .wrData(wrData), .wrValid(wrValid), .burstDone(burstDone),
    .recoveryBusy(recoveryBusy), .turnBusy(turnBusy), .mwrBusy(mwrBusy));
  lwp_ctl_model ctl (.cmd(cmd), .strobe(strobe), .dq(dq), .dmi(dmi));

  // Counts every committed beat.
  always @(posedge core_clk) nBeats <= nBeats + int'(wrValid);

  // Compares one value and counts the result.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // Runs one burst and waits, bounded, for its end pulse.
  task automatic run(input logic [2:0] c, input int beats, input logic [15:0] d, input logic [1:0] m);
    nBeats = 0;
    fork
      ctl.burst(c, 1'b1, beats, d, m);
      for (int i = 0; i < 3000 && burstDone !== 1'b1; i++) step(1);
    join
    step(1);
    check("beats", 16'(nBeats), 16'(beats));
  endtask : run

  task automatic plainWrite();
    run(CMD_WR, 16, 16'hA55A, 2'h0);
    check("data", wrData, 16'hA55A);
    check("rec", 16'(recoveryBusy), 16'h0001);
    check("turn", 16'(turnBusy), 16'h0001);
    step(5);
    check("turnEnd", 16'(turnBusy), 16'h0000);
    check("recHold", 16'(recoveryBusy), 16'h0001);
    step(4);
    check("recEnd", 16'(recoveryBusy), 16'h0000);
  endtask : plainWrite

  // Masked write with 32-beat mode still takes 16 beats and keeps lane 0.
  task automatic maskedWrite();
    bl32 = 1'b1;
    fork
      run(CMD_MWR1, 16, 16'hBEEF, 2'h1);
      begin
        step(3);
        check("mwr", 16'(mwrBusy), 16'h0001);
        step(CCDMW - 2);
        check("mwrLast", 16'(mwrBusy), 16'h0001);
        step(2);
        check("mwrEnd", 16'(mwrBusy), 16'h0000);
      end
    join
    check("merge", wrData, 16'hBE5A);
    run(CMD_WR, 32, 16'h0F0F, 2'h0);
    check("bl32", wrData, 16'h0F0F);
  endtask : maskedWrite

  // A write without its second cycle must commit nothing.
  task automatic droppedWrite();
    nBeats = 0;
    ctl.burst(CMD_WR, 1'b0, 4, 16'h3C3C, 2'h0);
    step(6);
    check("drop", 16'(nBeats), 16'h0000);
  endtask : droppedWrite

  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Watchdog: far beyond the few hundred cycles the tests need.
  initial
  begin
    #2000000;
    fail_count++;
    conclude();
  end

  initial
  begin
    resetn = 1'b0;
    bl32 = 1'b0;
    nBeats = 0;
    step(12);
    resetn = 1'b1;
    check("idle", {wrValid, burstDone, recoveryBusy, turnBusy, mwrBusy}, 16'h0000);
    plainWrite();
    maskedWrite();
    droppedWrite();
    conclude();
  end
endmodule : lwp_write_path_tb_top
